// >>> shared/pnr_pkg.sv
// shared constants for the non-prefetchable delayed read path
package pnr_pkg;
  localparam int PNR_AW = 32;
  localparam int PNR_DW = 32;
  localparam int PNR_CW = 4;
  localparam int PNR_BW = 4;
  // pci command codes of reads taken by this path
  localparam logic [3:0] PNR_CMD_IO_RD = 4'h2;
  localparam logic [3:0] PNR_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PNR_CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] PNR_CMD_MEM_RD_LINE = 4'hE;
  // read latency limit in clocks
  localparam int PNR_LAT_CLKS = 32768;
  localparam int PNR_LAT_W = 16;
  localparam logic [31:0] PNR_ADDR_ZERO = 32'h0000_0000;
  localparam logic [31:0] PNR_DATA_ZERO = 32'h0000_0000;
  // answer codes toward the pci target controller
  typedef enum logic [1:0] {PNR_TERM_NONE, PNR_TERM_RETRY, PNR_TERM_DISC_DATA} pnr_term_e;
endpackage

// >>> rtl/pnr_resp_reg.sv
// read response register holding interconnect data until pci completion
`timescale 1ns/1ps
`default_nettype none
module pnr_resp_reg
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // capture and discard
  input wire logic load,
  input wire logic [pnr_pkg::PNR_DW-1:0] load_data,
  input wire logic clear,
  // held response
  output logic valid_r,
  output logic [pnr_pkg::PNR_DW-1:0] data_r
);
  import pnr_pkg::*;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      valid_r <= 1'b0;
      data_r <= PNR_DATA_ZERO;
    end else if (load) begin
      valid_r <= 1'b1;
      data_r <= load_data;
    end else if (clear) begin
      valid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pnr_read_path.sv
// non-prefetchable delayed read path from pci target to interconnect master
`timescale 1ns/1ps
`default_nettype none
module pnr_read_path
#(
  parameter int LAT_CLKS = pnr_pkg::PNR_LAT_CLKS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // address translation base from the bridge
  input wire logic [pnr_pkg::PNR_AW-1:0] xlat_base,
  // pci target controller request
  input wire logic tgt_req,
  input wire logic tgt_np_hit,
  input wire logic tgt_io_hit,
  input wire logic tgt_pf_hit,
  input wire logic single_xfer_profile,
  input wire logic tgt_is_write,
  input wire logic [pnr_pkg::PNR_CW-1:0] tgt_cmd,
  input wire logic [pnr_pkg::PNR_AW-1:0] tgt_addr,
  input wire logic [pnr_pkg::PNR_BW-1:0] tgt_be,
  input wire logic np_write_busy,
  // pci target controller answer
  output pnr_pkg::pnr_term_e tgt_term,
  output logic tgt_abort,
  output logic [pnr_pkg::PNR_DW-1:0] tgt_rdata,
  // opposite-direction write ordering
  input wire logic rev_write_pending,
  // interconnect master port
  output logic mm_read,
  output logic [pnr_pkg::PNR_AW-1:0] mm_addr,
  output logic [pnr_pkg::PNR_BW-1:0] mm_byteenable,
  input wire logic mm_waitrequest,
  input wire logic mm_readdatavalid,
  input wire logic [pnr_pkg::PNR_DW-1:0] mm_readdata,
  // state visible to the bridge
  output logic np_read_busy
);
  import pnr_pkg::*;

  // issue: master port asked; wait: one beat owed; hold: data parked for the repeat
  typedef enum logic [1:0] {PNR_IDLE, PNR_ISSUE, PNR_WAIT, PNR_HOLD} pnr_state_e;

  pnr_state_e state_r, state_nxt;
  // command register and the address handed to the master port
  logic [PNR_CW-1:0] cmd_r;
  logic [PNR_AW-1:0] addr_r;
  logic [PNR_BW-1:0] be_r;
  logic [PNR_AW-1:0] mm_addr_r;
  // latency, ordering and late-beat bookkeeping
  logic [PNR_LAT_W-1:0] lat_cnt_r;
  logic order_block_r;
  logic drop_r;
  // completion data and the held response
  logic [PNR_DW-1:0] rdata_r;
  logic resp_valid;
  logic [PNR_DW-1:0] resp_data;

  localparam logic [PNR_LAT_W-1:0] LAT_LAST = PNR_LAT_W'(LAT_CLKS - 1);

  // state decode
  wire st_idle = (state_r == PNR_IDLE);
  wire st_issue = (state_r == PNR_ISSUE);
  wire st_wait = (state_r == PNR_WAIT);
  wire st_hold = (state_r == PNR_HOLD);

  // request decode: the four read commands share one behaviour
  wire cmd_io_rd = (tgt_cmd == PNR_CMD_IO_RD);
  wire cmd_mem_rd = (tgt_cmd == PNR_CMD_MEM_RD);
  wire cmd_mem_line = (tgt_cmd == PNR_CMD_MEM_RD_LINE);
  wire cmd_mem_mult = (tgt_cmd == PNR_CMD_MEM_RD_MULT);
  wire is_read_cmd = cmd_io_rd || cmd_mem_rd || cmd_mem_line || cmd_mem_mult;
  wire path_hit = tgt_np_hit || tgt_io_hit || (tgt_pf_hit && single_xfer_profile);
  wire any_req = tgt_req && path_hit;
  wire rd_req = any_req && is_read_cmd && !tgt_is_write;
  // writes belong to the write path; here they are only refused while a read holds the register
  wire wr_refuse = any_req && tgt_is_write && !st_idle;
  wire reg_busy = !st_idle || np_write_busy;
  wire capture = rd_req && !reg_busy;

  // a repeat is the same read only if all three fields agree
  wire cmd_same = (tgt_cmd == cmd_r);
  wire addr_same = (tgt_addr == addr_r);
  wire be_same = (tgt_be == be_r);
  wire req_match = cmd_same && addr_same && be_same;

  // completion and master-port handshake
  wire lat_expire = !st_idle && (lat_cnt_r == LAT_LAST);
  // data withheld while an earlier reverse write is outstanding
  wire data_ready = resp_valid && !order_block_r;
  wire complete = rd_req && st_hold && req_match && data_ready && !lat_expire;
  wire mm_accept = st_issue && !mm_waitrequest;
  // a read cut by expiry still owes its beat; that beat must not land on the next read
  wire beat_ok = mm_readdatavalid && !drop_r;
  wire resp_load = st_wait && beat_ok && !lat_expire;
  wire drop_set = lat_expire && st_wait && !beat_ok;
  wire resp_clear = complete || lat_expire;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PNR_IDLE: if (capture) state_nxt = PNR_ISSUE;
      PNR_ISSUE: if (mm_accept) state_nxt = PNR_WAIT;
      PNR_WAIT: if (beat_ok) state_nxt = PNR_HOLD;
      PNR_HOLD: if (complete) state_nxt = PNR_IDLE;
    endcase
    // expiry frees the register, but a read still offered on the master port is seen through first
    if (lat_expire && !st_issue) begin
      state_nxt = PNR_IDLE;
    end
  end

  // answer: disconnect with data only on a matching, ready repeat; retry other reads and refused writes; else none
  assign tgt_term = complete ? PNR_TERM_DISC_DATA :
                    (rd_req || wr_refuse) ? PNR_TERM_RETRY : PNR_TERM_NONE;
  assign tgt_abort = 1'b0;
  // data and master-port outputs come straight from registers
  assign tgt_rdata = rdata_r;
  assign np_read_busy = !st_idle;
  assign mm_read = st_issue;
  assign mm_addr = mm_addr_r;
  assign mm_byteenable = be_r;

  // state register; the command register below only moves on capture
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= PNR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one copy of the request, compared against every repeat
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_r <= '0;
      addr_r <= PNR_ADDR_ZERO;
      be_r <= '0;
    end else if (capture) begin
      cmd_r <= tgt_cmd;
      addr_r <= tgt_addr;
      be_r <= tgt_be;
    end
  end

  // translation done once at capture so the master port sees a settled address
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mm_addr_r <= PNR_ADDR_ZERO;
    end else if (capture) begin
      mm_addr_r <= xlat_base + tgt_addr;
    end
  end

  // counter runs from capture; cleared whenever the path is idle
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_r == PNR_IDLE) begin
      lat_cnt_r <= '0;
    end else if (!lat_expire) begin
      lat_cnt_r <= lat_cnt_r + 1'b1;
    end
  end

  // reverse write pending at capture blocks data until that write drains
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      order_block_r <= 1'b0;
    end else if (capture) begin
      order_block_r <= rev_write_pending;
    end else if (!rev_write_pending) begin
      order_block_r <= 1'b0;
    end
  end

  // completion data stands for the cycle after the disconnect
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= PNR_DATA_ZERO;
    end else if (complete) begin
      rdata_r <= resp_data;
    end
  end

  // beats come back in order, so the first one after a cut belongs to the cut read
  // only one owed beat is tracked; a second expiry before it lands would need a deeper count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drop_r <= 1'b0;
    end else if (drop_set) begin
      drop_r <= 1'b1;
    end else if (mm_readdatavalid) begin
      drop_r <= 1'b0;
    end
  end

  pnr_resp_reg u_resp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(resp_load),
    .load_data(mm_readdata),
    .clear(resp_clear),
    .valid_r(resp_valid),
    .data_r(resp_data)
  );
endmodule
`default_nettype wire

// >>> tb/pnr_read_path_assertions.sv
// port checker for the delayed read path
`timescale 1ns/1ps
`default_nettype none
module pnr_read_path_assertions
  import pnr_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tgt_req,
  input wire logic tgt_np_hit,
  input wire logic tgt_io_hit,
  input wire logic tgt_pf_hit,
  input wire logic single_xfer_profile,
  input wire logic [pnr_pkg::PNR_CW-1:0] tgt_cmd,
  input wire logic tgt_is_write,
  input wire logic np_write_busy,
  input wire pnr_pkg::pnr_term_e tgt_term,
  input wire logic tgt_abort,
  input wire logic mm_read,
  input wire logic mm_waitrequest,
  input wire logic np_read_busy
);
  wire path_hit = tgt_np_hit || tgt_io_hit || (tgt_pf_hit && single_xfer_profile);
  wire rd_cmd = (tgt_cmd == PNR_CMD_IO_RD) || (tgt_cmd == PNR_CMD_MEM_RD) ||
                (tgt_cmd == PNR_CMD_MEM_RD_MULT) || (tgt_cmd == PNR_CMD_MEM_RD_LINE);
  wire rd_ask = tgt_req && path_hit && rd_cmd && !tgt_is_write;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_issue; mm_read && !mm_waitrequest; endsequence
  sequence s_disc; tgt_term == PNR_TERM_DISC_DATA; endsequence
  a_no_abort: assert property (!tgt_abort) else $error("abort");
  a_wbusy_retry: assert property (rd_ask && np_write_busy |-> tgt_term == PNR_TERM_RETRY) else $error("wb");
  a_busy_retry: assert property (tgt_req && path_hit && tgt_is_write && np_read_busy |-> tgt_term == PNR_TERM_RETRY)
    else $error("busy");
  a_write_free: assert property (tgt_req && tgt_is_write && !np_read_busy |-> tgt_term == PNR_TERM_NONE)
    else $error("write answered");
  a_miss_none: assert property (tgt_req && !path_hit |-> tgt_term == PNR_TERM_NONE) else $error("miss");
  a_free_capture: assert property (rd_ask && !np_read_busy && !np_write_busy |->
    tgt_term == PNR_TERM_RETRY ##1 np_read_busy) else $error("no capture");
  a_capture_issue: assert property ($rose(np_read_busy) |-> mm_read && $past(tgt_req)) else $error("cap");
  a_disc_frees: assert property (s_disc |=> !np_read_busy) else $error("free");
  a_disc_ready: assert property (s_disc |-> np_read_busy && !mm_read) else $error("early");
  a_read_hold: assert property (mm_read && mm_waitrequest |=> mm_read) else $error("hold");
  a_single_read: assert property (s_issue |=> !mm_read) else $error("burst");
  a_idle_quiet: assert property ($rose(mm_read) |-> !$past(np_read_busy) && !$past(np_write_busy))
    else $error("idle");
endmodule
bind pnr_read_path pnr_read_path_assertions i_chk (.core_clk, .sys_rst, .tgt_req, .tgt_np_hit, .tgt_io_hit,
  .tgt_pf_hit, .single_xfer_profile, .tgt_cmd, .tgt_is_write,
  .np_write_busy, .tgt_term, .tgt_abort, .mm_read, .mm_waitrequest, .np_read_busy);
`default_nettype wire

// >>> tb/pnr_mm_slave.sv
// interconnect slave model with set wait states and read latency
`timescale 1ns/1ps
`default_nettype none
module pnr_mm_slave (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] wt,
  input wire logic [7:0] lat,
  input wire logic mm_read,
  input wire logic [31:0] mm_addr,
  input wire logic [3:0] mm_byteenable,
  output logic mm_waitrequest,
  output logic mm_readdatavalid,
  output var logic [31:0] mm_readdata
);
  logic [7:0] wc, lc;
  logic [31:0] d;
  assign mm_waitrequest = mm_read && wc != wt;
  always_ff @(posedge core_clk) begin
    wc <= mm_waitrequest ? wc + 8'h01 : 8'h00;
    mm_readdatavalid <= !sys_rst && lc == 8'h01;
    // data lines toggle when not valid so stale values never look good
    mm_readdata <= lc == 8'h01 ? d : (sys_rst ? 32'h0 : ~mm_readdata);
    lc <= sys_rst ? 8'h00 : lc - {7'h0, lc != 8'h00};
    if (mm_read && !mm_waitrequest) begin
      d <= mm_addr ^ {8{mm_byteenable}};
      lc <= lat;
    end
  end
endmodule
`default_nettype wire

// >>> tb/pnr_read_path_tb.sv
// self-checking bench for the delayed read path
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s %h %h", n, e, g); end end
module pnr_read_path_tb;
  import pnr_pkg::*;
  localparam logic [31:0] BASE = 32'h1000_0000;
  logic core_clk = 1'b0, sys_rst = 1'b1, tgt_req = 1'b0, np_write_busy = 1'b0, rev_write_pending = 1'b0;
  logic tgt_np_hit = 1'b0, tgt_io_hit = 1'b0, tgt_pf_hit = 1'b0, single_xfer_profile = 1'b0, tgt_is_write = 1'b0;
  logic tgt_abort, mm_read, mm_waitrequest, mm_readdatavalid, np_read_busy;
  logic [3:0] tgt_cmd = 4'h0, tgt_be = 4'h0, mm_byteenable;
  logic [7:0] wt = 8'h01, lat = 8'h02;
  logic [31:0] tgt_addr = 32'h0, tgt_rdata, mm_addr, mm_readdata;
  pnr_term_e tgt_term;
  int fails = 0, checks_done = 0;
  // short latency limit keeps the expiry case quick
  pnr_read_path #(.LAT_CLKS(64)) i_pnr_read_path (.core_clk, .sys_rst, .xlat_base(BASE), .tgt_req, .tgt_np_hit,
    .tgt_io_hit, .tgt_pf_hit, .single_xfer_profile, .tgt_is_write, .tgt_cmd, .tgt_addr, .tgt_be, .np_write_busy,
    .tgt_term, .tgt_abort, .tgt_rdata, .rev_write_pending, .mm_read, .mm_addr, .mm_byteenable, .mm_waitrequest,
    .mm_readdatavalid, .mm_readdata, .np_read_busy);
  pnr_mm_slave i_pnr_mm_slave (.core_clk, .sys_rst, .wt, .lat, .mm_read, .mm_addr, .mm_byteenable,
    .mm_waitrequest, .mm_readdatavalid, .mm_readdata);
  initial forever #10 core_clk = ~core_clk;
  // h packs write flag and hits: write, np, io, pf, profile
  task automatic req(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b, input logic [4:0] h,
                     input pnr_term_e t);
    @(negedge core_clk);
    {tgt_req, tgt_cmd, tgt_addr, tgt_be} = {1'b1, c, a, b};
    {tgt_is_write, tgt_np_hit, tgt_io_hit, tgt_pf_hit, single_xfer_profile} = h;
    #1 `CHK("term", t, tgt_term)
    @(negedge core_clk);
    tgt_req = 1'b0;
  endtask
  task automatic rd(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b, input logic [4:0] h);
    req(c, a, b, h, PNR_TERM_RETRY);
    req(c, a, b, h, PNR_TERM_RETRY);
    repeat (30) @(negedge core_clk);
    req(c, a, b, h, PNR_TERM_DISC_DATA);
    `CHK("rdata", (BASE + a) ^ {8{b}}, tgt_rdata)
  endtask
  task automatic t_cmds();
    logic [3:0] cm [4] = '{PNR_CMD_IO_RD, PNR_CMD_MEM_RD, PNR_CMD_MEM_RD_MULT, PNR_CMD_MEM_RD_LINE};
    logic [4:0] hi [4] = '{5'h08, 5'h04, 5'h03, 5'h08};
    for (int i = 0; i < 4; i++) begin
      rd(cm[i], 32'h100 * i + 32'h4, 4'h1 << i, hi[i]);
    end
    $display("t_cmds done");
  endtask
  task automatic t_busy();
    req(PNR_CMD_MEM_RD, 32'h40, 4'hF, 5'h08, PNR_TERM_RETRY);
    req(PNR_CMD_MEM_RD, 32'h44, 4'hF, 5'h08, PNR_TERM_RETRY);
    req(PNR_CMD_MEM_RD, 32'h40, 4'h3, 5'h08, PNR_TERM_RETRY);
    req(PNR_CMD_MEM_RD, 32'h40, 4'hF, 5'h18, PNR_TERM_RETRY);
    repeat (30) @(negedge core_clk);
    req(PNR_CMD_MEM_RD_LINE, 32'h40, 4'hF, 5'h08, PNR_TERM_RETRY);
    req(PNR_CMD_MEM_RD, 32'h40, 4'hF, 5'h08, PNR_TERM_DISC_DATA);
    np_write_busy = 1'b1;
    req(PNR_CMD_MEM_RD, 32'h44, 4'hF, 5'h08, PNR_TERM_RETRY);
    `CHK("busy", 1'b0, np_read_busy)
    np_write_busy = 1'b0;
    rd(PNR_CMD_MEM_RD, 32'h44, 4'hF, 5'h08);
    $display("t_busy done");
  endtask
  task automatic t_rev();
    {wt, lat, rev_write_pending} = {8'h06, 8'h14, 1'b1};
    req(PNR_CMD_IO_RD, 32'h80, 4'h5, 5'h04, PNR_TERM_RETRY);
    repeat (40) @(negedge core_clk);
    req(PNR_CMD_IO_RD, 32'h80, 4'h5, 5'h04, PNR_TERM_RETRY);
    rev_write_pending = 1'b0;
    req(PNR_CMD_IO_RD, 32'h80, 4'h5, 5'h04, PNR_TERM_DISC_DATA);
    `CHK("rdata", (BASE + 32'h80) ^ 32'h5555_5555, tgt_rdata)
    $display("t_rev done");
  endtask
  task automatic t_expire();
    req(PNR_CMD_MEM_RD, 32'hC0, 4'hF, 5'h08, PNR_TERM_RETRY);
    repeat (63) @(negedge core_clk);
    `CHK("busy", 1'b1, np_read_busy)
    @(negedge core_clk);
    `CHK("busy", 1'b0, np_read_busy)
    rd(PNR_CMD_MEM_RD, 32'hC0, 4'hF, 5'h08);
    $display("t_expire done");
  endtask
  task automatic t_none();
    req(PNR_CMD_MEM_RD, 32'h140, 4'hF, 5'h02, PNR_TERM_NONE);
    req(4'h7, 32'h140, 4'hF, 5'h18, PNR_TERM_NONE);
    `CHK("busy", 1'b0, np_read_busy)
    `CHK("abort", 1'b0, tgt_abort)
    $display("t_none done");
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    results();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    t_cmds();
    t_none();
    t_busy();
    t_rev();
    t_expire();
    results();
  end
endmodule
`default_nettype wire
